// ==== design/env_msg_framer.sv ====
// Framer for the standard environmental data message
//
// Overview of operation
// - First byte is type code 32
// - Second byte is cluster identifier low byte
// - Alert byte: fire down to low battery
// - Hatch flags from open/closed threshold compares
// - Health bits seven to three: fault flags
// - Health low three bits carry input gain
// - Fire bits seven to four: smoke, temperature
// - Fire bits three to zero: CO, O2, humidity, rapid
// - Diagnostic bit seven: second oxygen sensor selected
// - Diagnostic bits six to two: fault flags
// - Diagnostic bits one, zero: failed thermistor code
// - Fifteen sensor bytes follow in fixed order
// - Temperature fields carry preformed scaled values
// - Battery byte scaled at 3.3 over 128
// - Signal strength scaled at 3.3 over 256
// - CO field is scaled 8-second average
// - Oxygen field is selected sensor average
// - Humidity field offset by fifty
// - Wide range temperature is half degrees
// - Ionization level passes through unaltered
// - Photoelectric field is 8-sample average
// - Sound fields invalid in monitor mode
// - CR LF appended only in monitor mode
// - Sixteen-bit check value ends the body
// - Radio message starts 55 FF FF 00 FF
// - Monitor mode sends fields as ASCII hex
`default_nettype none
module env_msg_framer (
   // Clock and reset
   input wire logic clk_i,
   input wire logic rst_n_i,
   // Register port
   input wire logic [3:0] reg_addr_i,
   input wire logic [7:0] reg_wdata_i,
   input wire logic reg_wr_i,
   input wire logic reg_rd_i,
   output logic [7:0] reg_rdata_o,
   // Sensor and status inputs
   input wire frame_pkg::sense_in_type sense_i,
   input wire logic start_i,
   // Byte stream towards radio or serial port
   output logic tx_valid_o,
   output logic [7:0] tx_data_o,
   input wire logic tx_ready_i,
   output logic busy_o
);
   import frame_pkg::*;

   // ************************************************************
   // State
   // ************************************************************
   typedef struct packed {
      phase_type phase;
      logic [4:0] idx;
      logic nib;             // Second hex character of a byte
      logic mon;             // Monitor mode of the running message
      logic ctrl_mon;        // Monitor mode as set by software
      logic [7:0] open_thr;
      logic [7:0] close_thr;
      logic [15:0] count;    // Messages completed
      snap_type snap;
      logic [15:0] crc;
      logic [7:0] data;
      logic [7:0] rdata;
   } state_type;

   state_type s_q;
   state_type s_d;

   // ************************************************************
   // Functions
   // ************************************************************
   // One byte through the check value, most significant bit first
   function automatic logic [15:0] crc_upd(input logic [15:0] c_in,
                                           input logic [7:0] b);
      logic [15:0] c;
      c = c_in ^ {b, 8'h00};
      for (int k = 0; k < 8; k++) begin
         c = c[15] ? ({c[14:0], 1'b0} ^ CRC_POLY) : {c[14:0], 1'b0};
      end
      return c;
   endfunction : crc_upd

   // ASCII hex digit for one nibble
   function automatic logic [7:0] hex_char(input logic [3:0] n);
      return (n < 4'hA) ? (CHAR_ZERO + {4'h0, n})
                        : (CHAR_ALPHA + {4'h0, n});
   endfunction : hex_char

   // Binary body byte at a given position
   function automatic logic [7:0] body_byte(input snap_type sn,
                                            input logic [4:0] i);
      logic [4:0] k;
      k = 5'(i - SENSOR_BASE);
      case (i)
         5'h00: return MSG_TYPE_STD;
         5'h01: return sn.cluster_lsb;
         5'h02: return sn.alert;
         5'h03: return sn.health;
         5'h04: return sn.fire_crit;
         5'h05: return sn.diag;
         default: begin
            if (k < 5'(FIELD_COUNT)) begin
               return sn.sensor[k[3:0]];
            end else begin
               return 8'h00;
            end
         end
      endcase
   endfunction : body_byte

   // Character presented for a given position in the message
   function automatic logic [7:0] pick_char(input state_type s);
      logic [7:0] b;
      b = 8'h00;
      case (s.phase)
         ST_SYNC: return SYNC_SEQ[6'(39 - 8 * s.idx) -: 8];
         ST_BODY: b = body_byte(s.snap, s.idx);
         ST_CHECK: b = (s.idx == 5'h00) ? s.crc[15:8]
                                        : s.crc[7:0];
         ST_EOL: return (s.idx == 5'h00) ? CHAR_CR : CHAR_LF;
         default: return 8'h00;
      endcase
      if (s.mon) begin
         return hex_char(s.nib ? b[3:0] : b[7:4]);
      end
      return b;
   endfunction : pick_char

   // ************************************************************
   // Snapshot
   // ************************************************************
   // Scaling of every sensor byte is done upstream; the framer keeps the
   // values as they stand at start so the check value matches them.
   snap_type snap_new;
   logic hatch_open;
   logic hatch_closed;

   always_comb begin
      hatch_open = sense_i.hatch > s_q.open_thr;
      hatch_closed = sense_i.hatch < s_q.close_thr;
      snap_new.cluster_lsb = sense_i.cluster_id[7:0];
      snap_new.alert = {sense_i.alert[5:1], hatch_open,
                        hatch_closed, sense_i.alert[0]};
      snap_new.health = {sense_i.health, sense_i.gain};
      snap_new.fire_crit = sense_i.fire_crit;
      snap_new.diag = {sense_i.o2_sel, sense_i.diag,
                       sense_i.therm_fail};
      snap_new.sensor = sense_i.sensor;
      if (s_q.ctrl_mon) begin
         // Sound levels mean nothing in monitor mode, so they go out zero
         snap_new.sensor[SND_NOW_IDX] = 8'h00;
         snap_new.sensor[SND_AVG_IDX] = 8'h00;
      end
   end

   // ************************************************************
   // Next state
   // ************************************************************
   logic accept;
   logic go;
   logic last_char;

   always_comb begin
      s_d = s_q;
      accept = (s_q.phase != ST_IDLE) && tx_ready_i;
      go = (s_q.phase == ST_IDLE) && (start_i ||
           (reg_wr_i && reg_addr_i == REG_CTRL &&
            reg_wdata_i[CTRL_START_BIT]));
      last_char = !(s_q.mon && (s_q.phase == ST_BODY ||
                                s_q.phase == ST_CHECK)) || s_q.nib;

      // Register writes
      if (reg_wr_i) begin
         case (reg_addr_i)
            REG_CTRL: s_d.ctrl_mon = reg_wdata_i[CTRL_MON_BIT];
            REG_OPEN_THR: s_d.open_thr = reg_wdata_i;
            REG_CLOSE_THR: s_d.close_thr = reg_wdata_i;
            default: ;
         endcase
      end

      // Start is ignored while a message is in flight
      if (go) begin
         s_d.snap = snap_new;
         s_d.mon = s_q.ctrl_mon;
         s_d.crc = CRC_INIT;
         s_d.idx = 5'h00;
         s_d.nib = 1'b0;
         s_d.phase = s_q.ctrl_mon ? ST_BODY : ST_SYNC;
      end else if (accept && !last_char) begin
         s_d.nib = 1'b1;
      end else if (accept) begin
         s_d.nib = 1'b0;
         s_d.idx = 5'(s_q.idx + 5'h01);
         case (s_q.phase)
            ST_SYNC: begin
               if (s_q.idx == SYNC_LEN - 5'h01) begin
                  s_d.phase = ST_BODY;
                  s_d.idx = 5'h00;
               end
            end
            ST_BODY: begin
               // Check value covers the binary body, not the ASCII form
               s_d.crc = crc_upd(s_q.crc,
                                 body_byte(s_q.snap, s_q.idx));
               if (s_q.idx == BODY_LEN - 5'h01) begin
                  s_d.phase = ST_CHECK;
                  s_d.idx = 5'h00;
               end
            end
            ST_CHECK: begin
               if (s_q.idx == CHECK_LEN - 5'h01) begin
                  s_d.phase = s_q.mon ? ST_EOL : ST_IDLE;
                  s_d.idx = 5'h00;
               end
            end
            ST_EOL: begin
               if (s_q.idx == EOL_LEN - 5'h01) begin
                  s_d.phase = ST_IDLE;
                  s_d.idx = 5'h00;
               end
            end
            default: s_d.phase = ST_IDLE;
         endcase
         if (s_d.phase == ST_IDLE) begin
            s_d.count = 16'(s_q.count + 16'h0001);
         end
      end

      // Character for the position just reached
      s_d.data = (s_d.phase == ST_IDLE) ? 8'h00 : pick_char(s_d);

      // Read data stands in the cycle after the strobe only
      s_d.rdata = 8'h00;
      if (reg_rd_i) begin
         case (reg_addr_i)
            REG_CTRL: s_d.rdata = {7'h00, s_q.ctrl_mon};
            REG_OPEN_THR: s_d.rdata = s_q.open_thr;
            REG_CLOSE_THR: s_d.rdata = s_q.close_thr;
            REG_STATUS: s_d.rdata = {6'h00, s_q.mon,
                                     s_q.phase != ST_IDLE};
            REG_COUNT: s_d.rdata = s_q.count[7:0];
            default: s_d.rdata = 8'h00;
         endcase
      end
   end

   // ************************************************************
   // Registers
   // ************************************************************
   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         s_q <= '0;
         s_q.phase <= ST_IDLE;
         s_q.open_thr <= OPEN_THR_RST;
         s_q.close_thr <= CLOSE_THR_RST;
      end else begin
         s_q <= s_d;
      end
   end

   // Outputs; valid follows the phase so it needs no flop of its own
   assign tx_valid_o = s_q.phase != ST_IDLE;
   assign tx_data_o = s_q.data;
   assign busy_o = s_q.phase != ST_IDLE;
   assign reg_rdata_o = s_q.rdata;

   // ************************************************************
   // Assertions
   // ************************************************************
   logic is_hex;
   assign is_hex = (tx_data_o >= 8'h30 && tx_data_o <= 8'h39) ||
                   (tx_data_o >= 8'h41 && tx_data_o <= 8'h46);

   AST_SYNC_FIRST: assert property (@(posedge clk_i) disable iff (!rst_n_i)
      go && !s_q.ctrl_mon |=> tx_valid_o && tx_data_o == 8'h55)
      else $error("radio message does not open with 55");

   AST_MON_FIRST: assert property (@(posedge clk_i) disable iff (!rst_n_i)
      go && s_q.ctrl_mon |=> tx_valid_o && tx_data_o == 8'h32)
      else $error("monitor message does not open with type digit");

   AST_TYPE: assert property (@(posedge clk_i) disable iff (!rst_n_i)
      s_q.phase == ST_BODY && s_q.idx == 5'h00 && !s_q.mon
      |-> tx_data_o == 8'h20)
      else $error("type code is not 32");

   AST_CLUSTER: assert property (@(posedge clk_i) disable iff (!rst_n_i)
      s_q.phase == ST_BODY && s_q.idx == 5'h01 && !s_q.mon
      |-> tx_data_o == s_q.snap.cluster_lsb)
      else $error("cluster byte out of place");

   AST_HATCH: assert property (@(posedge clk_i) disable iff (!rst_n_i)
      go |=> s_q.snap.alert[2] == ($past(sense_i.hatch) >
                                   $past(s_q.open_thr)))
      else $error("open hatch flag wrong");

   AST_HATCH_SHUT: assert property (@(posedge clk_i) disable iff (!rst_n_i)
      go |=> s_q.snap.alert[1] == ($past(sense_i.hatch) <
                                   $past(s_q.close_thr)))
      else $error("closed hatch flag wrong");

   AST_GAIN: assert property (@(posedge clk_i) disable iff (!rst_n_i)
      go |=> s_q.snap.health[2:0] == $past(sense_i.gain))
      else $error("gain not in health byte");

   AST_EOL_MON: assert property (@(posedge clk_i) disable iff (!rst_n_i)
      s_q.phase == ST_EOL |-> s_q.mon)
      else $error("line end on radio link");

   AST_CRC_HIGH: assert property (@(posedge clk_i) disable iff (!rst_n_i)
      s_q.phase == ST_CHECK && s_q.idx == 5'h00 && !s_q.mon
      |-> tx_data_o == s_q.crc[15:8])
      else $error("check value not high byte first");

   AST_ASCII: assert property (@(posedge clk_i) disable iff (!rst_n_i)
      s_q.mon && (s_q.phase == ST_BODY || s_q.phase == ST_CHECK)
      |-> is_hex)
      else $error("monitor character is not hex");

   AST_FROZEN: assert property (@(posedge clk_i) disable iff (!rst_n_i)
      busy_o && !go |=> $stable(s_q.snap))
      else $error("snapshot changed mid message");

   AST_SOUND: assert property (@(posedge clk_i) disable iff (!rst_n_i)
      go && s_q.ctrl_mon |=> s_q.snap.sensor[SND_NOW_IDX] == 8'h00 &&
      s_q.snap.sensor[SND_AVG_IDX] == 8'h00)
      else $error("sound level sent in monitor mode");

   AST_CRC_LEN: assert property (@(posedge clk_i) disable iff (!rst_n_i)
      s_q.phase == ST_BODY && s_q.idx == BODY_LEN - 5'h01 && accept
      && last_char |=> s_q.phase == ST_CHECK)
      else $error("check value does not follow body");
endmodule : env_msg_framer
`default_nettype wire

// ==== design/frame_pkg.sv ====
// Constants and types for the environmental data message framer
`default_nettype none
package frame_pkg;
   // ************************************************************
   // Message layout
   // ************************************************************
   localparam logic [7:0] MSG_TYPE_STD = 8'h20;     // Standard data report
   localparam logic [39:0] SYNC_SEQ = 40'h55FFFF00FF; // Lock pattern + header
   localparam logic [4:0] SYNC_LEN = 5'h05;
   localparam logic [4:0] BODY_LEN = 5'h15;         // 21 bytes before check
   localparam logic [4:0] SENSOR_BASE = 5'h06;      // First scaled sensor
   localparam int FIELD_COUNT = 15;
   localparam logic [4:0] CHECK_LEN = 5'h02;
   localparam logic [4:0] EOL_LEN = 5'h02;
   localparam logic [3:0] SND_NOW_IDX = 4'hD;       // Present sound level
   localparam logic [3:0] SND_AVG_IDX = 4'hE;       // Average sound level
   localparam logic [7:0] CHAR_CR = 8'h0D;
   localparam logic [7:0] CHAR_LF = 8'h0A;
   localparam logic [7:0] CHAR_ZERO = 8'h30;
   localparam logic [7:0] CHAR_ALPHA = 8'h37;       // 'A' minus ten
   // ************************************************************
   // Check value
   // ************************************************************
   localparam logic [15:0] CRC_POLY = 16'h1021;
   localparam logic [15:0] CRC_INIT = 16'hFFFF;
   // ************************************************************
   // Register map
   // ************************************************************
   localparam logic [3:0] REG_CTRL = 4'h0;
   localparam logic [3:0] REG_OPEN_THR = 4'h1;
   localparam logic [3:0] REG_CLOSE_THR = 4'h2;
   localparam logic [3:0] REG_STATUS = 4'h3;
   localparam logic [3:0] REG_COUNT = 4'h4;
   localparam int CTRL_MON_BIT = 0;
   localparam int CTRL_START_BIT = 1;
   localparam int STAT_BUSY_BIT = 0;
   localparam int STAT_MON_BIT = 1;
   localparam logic [7:0] OPEN_THR_RST = 8'hC0;
   localparam logic [7:0] CLOSE_THR_RST = 8'h40;
   // ************************************************************
   // Types
   // ************************************************************
   typedef enum logic [2:0] {
      ST_IDLE, ST_SYNC, ST_BODY, ST_CHECK, ST_EOL
   } phase_type;

   // Live condition of the cluster, as seen by the framer
   typedef struct packed {
      logic [31:0] cluster_id;
      logic [5:0] alert;        // Fire, flood, temp, CO, pressure, low batt
      logic [7:0] hatch;        // Hatch reading
      logic [4:0] health;       // Supply, thermistor, lin hi, lin lo, RSSI
      logic [2:0] gain;         // Sound/vibration input gain
      logic [7:0] fire_crit;    // Multi-criterion fire bits
      logic o2_sel;             // Second oxygen sensor selected
      logic [4:0] diag;         // Batt2, LED, CO loop, sens low, sens1 low
      logic [1:0] therm_fail;   // Failed thermistor code
      logic [0:14][7:0] sensor; // Scaled sensor bytes in message order
   } sense_in_type;

   // Frozen copy of the message fields
   typedef struct packed {
      logic [7:0] cluster_lsb;
      logic [7:0] alert;
      logic [7:0] health;
      logic [7:0] fire_crit;
      logic [7:0] diag;
      logic [0:14][7:0] sensor;
   } snap_type;
endpackage : frame_pkg
`default_nettype wire

// ==== sim/msg_sink.sv ====
// Far-side model: radio receiver or monitor terminal taking the byte stream
`default_nettype none
module msg_sink (
   // Clock and reset
   input wire logic clk_i,
   input wire logic rst_n_i,
   // Byte stream from the framer
   input wire logic valid_i,
   input wire logic [7:0] data_i,
   output logic ready_o,
   // Test control
   input wire logic stall_i
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [7:0] got [0:255];
   int cnt;
   logic phase_q;
   // Slow mode drops ready every other cycle, so held data gets exercised
   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         ready_o <= 1'b0;
         phase_q <= 1'b0;
         cnt <= 0;
      end else begin
         phase_q <= ~phase_q;
         ready_o <= !stall_i || phase_q;
         if (valid_i && ready_o && cnt < 256) begin
            got[cnt] <= data_i;
            cnt <= cnt + 1;
         end
      end
   end
endmodule : msg_sink
`default_nettype wire

// ==== sim/tb_top.sv ====
// Self-checking testbench for the environmental data message framer
`default_nettype none
module tb_top;
   timeunit 1ns;
   timeprecision 1ps;
   import frame_pkg::*;
   logic clk_i, rst_n_i, reg_wr, reg_rd, start, tx_valid, tx_ready;
   logic busy, stall;
   logic [3:0] reg_addr;
   logic [7:0] reg_wdata, reg_rdata, tx_data;
   sense_in_type sense, s;
   int n_errors = 0;
   int total_checks = 0;
   int cycles = 0;
   int nx, b0;
   logic [7:0] ex [0:63];

   env_msg_framer i_env_msg_framer (.clk_i(clk_i), .rst_n_i(rst_n_i),
      .reg_addr_i(reg_addr), .reg_wdata_i(reg_wdata), .reg_wr_i(reg_wr),
      .reg_rd_i(reg_rd), .reg_rdata_o(reg_rdata), .sense_i(sense),
      .start_i(start), .tx_valid_o(tx_valid), .tx_data_o(tx_data),
      .tx_ready_i(tx_ready), .busy_o(busy));
   msg_sink i_msg_sink (.clk_i(clk_i), .rst_n_i(rst_n_i),
      .valid_i(tx_valid), .data_i(tx_data), .ready_o(tx_ready),
      .stall_i(stall));

   // ************************************************************
   // Helpers
   // ************************************************************
   task automatic close_out();
      $display("checks %0d errors %0d", total_checks, n_errors);
      if (n_errors == 0 && total_checks > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask : close_out

   task automatic check(input logic [7:0] seen, input logic [7:0] exp);
      total_checks++;
      if (seen !== exp) begin
         n_errors++;
         $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
      end
   endtask : check

   function automatic logic [7:0] hexc(input logic [3:0] n);
      return (n < 4'hA) ? 8'h30 + {4'h0, n} : 8'h37 + {4'h0, n};
   endfunction : hexc

   function automatic sense_in_type mk(input logic [7:0] h);
      sense_in_type v;
      v.cluster_id = 32'h123456A7;
      v.alert = 6'h2D;
      v.hatch = h;
      v.health = 5'h16;
      v.gain = 3'h3;
      v.fire_crit = 8'hA5;
      v.o2_sel = 1'b1;
      v.diag = 5'h0B;
      v.therm_fail = 2'h2;
      // Distinct bytes per slot so a swapped field order shows up
      for (int k = 0; k < 15; k++)
         v.sensor[k] = 8'(8'h11 * (k + 1));
      return v;
   endfunction : mk

   // Expected character stream, worked out independently of the design
   task automatic build_exp(input sense_in_type v, input logic mon,
                            input logic [7:0] op, input logic [7:0] cl);
      logic [7:0] b [0:22];
      logic [15:0] crc;
      logic [39:0] sync;
      crc = CRC_INIT;
      sync = 40'h55FFFF00FF;
      b[0] = 8'h20;
      b[1] = v.cluster_id[7:0];
      b[2] = {v.alert[5:1], v.hatch > op, v.hatch < cl, v.alert[0]};
      b[3] = {v.health, v.gain};
      b[4] = v.fire_crit;
      b[5] = {v.o2_sel, v.diag, v.therm_fail};
      for (int k = 0; k < 15; k++)
         b[6 + k] = (mon && k > 12) ? 8'h00 : v.sensor[k];
      for (int k = 0; k < 21; k++) begin
         crc = crc ^ {b[k], 8'h00};
         for (int j = 0; j < 8; j++)
            crc = crc[15] ? (crc << 1) ^ CRC_POLY : crc << 1;
      end
      b[21] = crc[15:8];
      b[22] = crc[7:0];
      if (mon) begin
         for (int k = 0; k < 23; k++) begin
            ex[2 * k] = hexc(b[k][7:4]);
            ex[2 * k + 1] = hexc(b[k][3:0]);
         end
         ex[46] = 8'h0D;
         ex[47] = 8'h0A;
         nx = 48;
      end else begin
         for (int k = 0; k < 5; k++)
            ex[k] = sync[39 - 8 * k -: 8];
         for (int k = 0; k < 23; k++)
            ex[5 + k] = b[k];
         nx = 28;
      end
   endtask : build_exp

   task automatic wr(input logic [3:0] a, input logic [7:0] d);
      @(posedge clk_i);
      reg_addr <= a;
      reg_wdata <= d;
      reg_wr <= 1'b1;
      @(posedge clk_i);
      reg_wr <= 1'b0;
   endtask : wr

   task automatic rd_chk(input logic [3:0] a, input logic [7:0] e);
      @(posedge clk_i);
      reg_addr <= a;
      reg_rd <= 1'b1;
      @(posedge clk_i);
      reg_rd <= 1'b0;
      #1;
      check(reg_rdata, e);
   endtask : rd_chk

   // Bounded wait: a framer that never drops busy must not hang the run
   task automatic wait_done();
      int n;
      // Let the edge that took the start settle before busy is read
      #1;
      n = 0;
      while (busy !== 1'b0 && n < 400) begin
         @(posedge clk_i);
         #1;
         n++;
      end
      check({7'h00, busy}, 8'h00);
   endtask : wait_done

   task automatic check_msg();
      check({7'h00, tx_valid}, 8'h00);
      check(8'(i_msg_sink.cnt - b0), 8'(nx));
      for (int k = 0; k < nx; k++)
         check(i_msg_sink.got[b0 + k], ex[k]);
   endtask : check_msg

   // ************************************************************
   // Scenarios
   // ************************************************************
   task automatic t_regs();
      rd_chk(4'h1, 8'hC0);
      rd_chk(4'h2, 8'h40);
      rd_chk(4'h0, 8'h00);
      rd_chk(4'h3, 8'h00);
      rd_chk(4'h4, 8'h00);
      wr(4'hF, 8'hAA);
      rd_chk(4'hF, 8'h00);
   endtask : t_regs

   task automatic t_radio();
      s = mk(8'hD0);
      @(posedge clk_i);
      sense <= s;
      build_exp(s, 1'b0, 8'hC0, 8'h40);
      b0 = i_msg_sink.cnt;
      @(posedge clk_i);
      start <= 1'b1;
      @(posedge clk_i);
      start <= 1'b0;
      wait_done();
      check_msg();
      check(i_msg_sink.got[b0 + 5], 8'h20);
      check(i_msg_sink.got[b0 + 6], 8'hA7);
      check(i_msg_sink.got[b0 + 7], 8'hB5);
      check(i_msg_sink.got[b0 + 8], 8'hB3);
      check(i_msg_sink.got[b0 + 9], 8'hA5);
      check(i_msg_sink.got[b0 + 10], 8'hAE);
      rd_chk(4'h4, 8'h01);
   endtask : t_radio

   // Stalled sink, live inputs flipped and a start retried mid-message
   task automatic t_stall();
      wr(4'h1, 8'hF0);
      wr(4'h2, 8'hE0);
      rd_chk(4'h1, 8'hF0);
      rd_chk(4'h2, 8'hE0);
      @(posedge clk_i);
      s = mk(8'hD0);
      stall <= 1'b1;
      sense <= s;
      build_exp(s, 1'b0, 8'hF0, 8'hE0);
      b0 = i_msg_sink.cnt;
      wr(4'h0, 8'h02);
      sense <= sense_in_type'(~s);
      start <= 1'b1;
      @(posedge clk_i);
      start <= 1'b0;
      wait_done();
      repeat (5) @(posedge clk_i);
      check_msg();
      check(i_msg_sink.got[b0 + 7], 8'hB3);
      stall <= 1'b0;
   endtask : t_stall

   // Monitor mode, hatch exactly on the open threshold
   task automatic t_mon();
      s = mk(8'hF0);
      @(posedge clk_i);
      sense <= s;
      build_exp(s, 1'b1, 8'hF0, 8'hE0);
      wr(4'h0, 8'h01);
      rd_chk(4'h0, 8'h01);
      b0 = i_msg_sink.cnt;
      wr(4'h0, 8'h03);
      rd_chk(4'h3, 8'h03);
      wait_done();
      check_msg();
      check(i_msg_sink.got[b0], 8'h32);
      check(i_msg_sink.got[b0 + 5], 8'h31);
      for (int k = 38; k < 42; k++)
         check(i_msg_sink.got[b0 + k], 8'h30);
      check(i_msg_sink.got[b0 + 47], 8'h0A);
      rd_chk(4'h4, 8'h03);
      wr(4'h0, 8'h00);
   endtask : t_mon

   // ************************************************************
   // Clock, timeout and main sequence
   // ************************************************************
   initial begin
      clk_i = 1'b0;
      forever #10 clk_i = ~clk_i;
   end

   always @(posedge clk_i) begin
      cycles <= cycles + 1;
      if (cycles == 20000) begin
         n_errors++;
         close_out();
      end
   end

   initial begin
      rst_n_i = 1'b0;
      reg_addr = 4'h0;
      reg_wdata = 8'h00;
      reg_wr = 1'b0;
      reg_rd = 1'b0;
      start = 1'b0;
      stall = 1'b0;
      sense = '0;
      repeat (20) @(posedge clk_i);
      rst_n_i <= 1'b1;
      t_regs();
      t_radio();
      t_stall();
      t_mon();
      close_out();
   end
endmodule : tb_top
`default_nettype wire
